// ### qaos_pkg.sv
// Purpose: Shared constants and types for the quad converter serializer
// Assumes: 10 MHz hclk, AHB-Lite register access
// Notes: One hclk cycle carries one serial bit period
package qaos_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_DRV = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	// Driver register fields
	localparam int DRV_SEL_LSB = 0;
	localparam int DRV_TERM_BIT = 3;
	// Mode register fields
	localparam int MODE_ONE_LANE_BIT = 0;
	localparam int MODE_SER_LSB = 1;
	localparam int MODE_DCS_OFF_BIT = 3;
	// Driver current codes, ascending
	localparam logic [2:0] CUR_1P75 = 3'h0;
	localparam logic [2:0] CUR_2P1 = 3'h1;
	localparam logic [2:0] CUR_2P5 = 3'h2;
	localparam logic [2:0] CUR_3P0 = 3'h3;
	localparam logic [2:0] CUR_3P5 = 3'h4;
	localparam logic [2:0] CUR_4P0 = 3'h5;
	localparam logic [2:0] CUR_4P5 = 3'h6;
	// Serialization length codes
	localparam logic [1:0] SER_16 = 2'h0;
	localparam logic [1:0] SER_14 = 2'h1;
	localparam logic [1:0] SER_12 = 2'h2;
	// Reset values
	localparam logic [3:0] DRV_RST = 4'h4;
	localparam logic [3:0] MODE_RST = 4'h0;
	// Timing
	localparam int CLK_NS = 100;
	localparam int RELOCK_US = 25;
	localparam int RELOCK_CYC = (RELOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] LOCK_LAST = 8'(RELOCK_CYC - 1);
	localparam logic [7:0] STOP_CYC = 8'hFF;
	localparam logic [7:0] PERIOD_TOL = 8'h01;
	// AHB
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	// Link states, Gray along idle, relock, run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RELOCK = 2'b01,
		ST_RUN = 2'b11
	} qaos_link_type;
endpackage : qaos_pkg

// ### qaos_serializer.sv
// Purpose: Quad channel serializer with forwarded clock and frame marker
// Assumes: Encode clock and strap pins are asynchronous to hclk
// Notes: One serial bit per hclk cycle; forwarded clock toggles per bit
// Overview of operation
// R1 - Two-lane sends two bits, one-lane one
// R2 - Sixteen, fourteen or twelve bit serialization
// R3 - Receiver captures on both clock edges
// R4 - Frame marker shows start of new result
// R5 - Two-lane fourteen-bit halves frame rate
// R6 - System keeps lane rate within limit
// R7 - Encode clock gives minimum sample rate
// R8 - Two-lane clock and bit rate ratios
// R9 - One-lane clock ratios, frame per sample
// R10 - Slower grades limit applied sample rate
// R11 - Current defaults mid, register picks seven
// R12 - Strap mode clock pin picks current
// R13 - Termination enable doubles driver current
// R14 - Strap mode data out pin enables termination
// R15 - Termination only with low currents; the logic allows termination with any current code
// R16 - Outputs valid only after relock interval
// R17 - Stabilizer forced on in strap mode
// R18 - Register may disable duty stabilizer
// R19 - All channels loaded on same edge
// R20 - Mode registers written by software port
// R21 - One-lane leaves second lanes idle
// R22 - Strap mode select pin picks lanes
// R23 - Pad bits follow data, set on overrange
// R24 - Most significant first, alternate lane split
// R25 - All outputs step on one bit clock
`timescale 1ns/1ps
`default_nettype none
module qaos_serializer
	import qaos_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic sample_clock_pos,
	input wire logic sample_clock_neg,
	input wire logic programming_mode_strap,
	input wire logic cs_pin,
	input wire logic sck_pin,
	input wire logic sdo_in,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic [47:0] ch_data,
	input wire logic [3:0] ch_overrange,
	output logic [3:0] lane_a,
	output logic [3:0] lane_b,
	output logic lane_b_enable,
	output logic forwarded_bit_clock,
	output logic frame_marker,
	output logic outputs_valid,
	output logic [2:0] drive_current_sel,
	output logic drive_doubled,
	output logic term_enable,
	output logic dcs_enable
);
	// Whole module state
	typedef struct packed {
		logic [5:0] sy1; // Pin synchronizer, first stage
		logic [5:0] sy2; // Pin synchronizer, second stage
		logic enc_prev; // Encode level, previous
		logic act; // Bus data phase pending
		logic wr; // Pending phase is a write
		logic [1:0] idx; // Pending register index
		logic [31:0] rdata; // Read data
		logic [3:0] output_driver_config_reg; // Current and termination
		logic [3:0] mode; // Lanes, length, stabilizer
		qaos_link_type link; // Clock lock state
		logic [7:0] per_cnt; // Cycles since encode edge
		logic [7:0] last_per; // Last measured period
		logic [7:0] lock_cnt; // Relock timer
		logic [63:0] sh; // Four 16-bit shifters
		logic [3:0] pos; // Bit period within word
		logic [4:0] len; // Bit periods per word
		logic busy; // Word in flight
		logic odd; // Odd sample of a pair
		logic cur_two; // Lane mode of word in flight
		logic [1:0] cur_ser; // Length of word in flight
		logic [3:0] la; // Lane A bits
		logic [3:0] lb; // Lane B bits
		logic fbc; // Forwarded clock
		logic fr; // Frame marker
		logic [2:0] cur_sel; // Effective current code
		logic term; // Effective termination
		logic dcs; // Effective stabilizer
		logic two; // Effective two-lane
		logic [1:0] ser; // Effective length
	} qaos_state_type;

	// Reset image
	localparam qaos_state_type ST_RST = '{
		output_driver_config_reg: DRV_RST,
		mode: MODE_RST,
		link: ST_IDLE,
		odd: 1'b1,
		cur_sel: CUR_3P5,
		dcs: 1'b1,
		two: 1'b1,
		ser: SER_16,
		default: '0
	};

	qaos_state_type q; // Registered state
	qaos_state_type d; // Next state
	logic enc; // Synchronized encode level
	logic edge_s; // Encode rising edge
	logic run; // Link running
	logic fchg; // Encode frequency changed
	logic [15:0] w; // Word being loaded

	// Padded sample word, MSB first
	function automatic logic [15:0] build_word(input logic [11:0] dat,
		input logic ovr, input logic [1:0] ser);
		logic [15:0] r;
		r = {dat, 4'h0};
		if (ser != SER_12) begin
			r = {dat, ovr, ovr, 2'b00}; // R23
		end
		return r;
	endfunction : build_word

	// Bit periods per lane for a word
	function automatic logic [4:0] len_of(input logic [1:0] ser, input logic two);
		logic [4:0] n;
		case (ser)
			SER_14: n = 5'd14;
			SER_12: n = 5'd12;
			default: n = 5'd16;
		endcase
		return two ? (n >> 1) : n; // R2 R8 R9
	endfunction : len_of

	// Register index from byte address
	function automatic logic [1:0] decode(input logic [7:0] a);
		logic [1:0] i;
		case (a)
			ADDR_DRV: i = 2'd0;
			ADDR_MODE: i = 2'd1;
			ADDR_STAT: i = 2'd2;
			default: i = 2'd3;
		endcase
		return i;
	endfunction : decode

	// Next-state logic
	always_comb begin
		d = q;
		w = 16'h0000;
		// Two-flop capture of outside pins
		d.sy1 = {sample_clock_pos, sample_clock_neg, cs_pin, sck_pin, sdo_in,
			programming_mode_strap};
		d.sy2 = q.sy1;
		enc = q.sy2[5] & ~q.sy2[4];
		d.enc_prev = enc;
		edge_s = enc & ~q.enc_prev;
		run = (q.link == ST_RUN);

		// Effective configuration
		if (q.sy2[0]) begin
			// Strap mode: pins pick a reduced set
			d.two = ~q.sy2[3]; // R22
			d.cur_sel = q.sy2[2] ? CUR_1P75 : CUR_3P5; // R12
			d.term = q.sy2[1]; // R14
			d.dcs = 1'b1; // R17
			d.ser = SER_16;
		end else begin
			// Software mode: registers decide
			d.two = ~q.mode[MODE_ONE_LANE_BIT];
			d.cur_sel = q.output_driver_config_reg[DRV_SEL_LSB +: 3]; // R11
			if (d.cur_sel > CUR_4P5) begin
				d.cur_sel = CUR_4P5;
			end
			d.term = q.output_driver_config_reg[DRV_TERM_BIT]; // R13
			d.dcs = ~q.mode[MODE_DCS_OFF_BIT]; // R18
			d.ser = q.mode[MODE_SER_LSB +: 2];
			if (d.ser == 2'h3) begin
				d.ser = SER_16;
			end
		end

		// Bus data phase: write into register
		if (q.act && q.wr) begin
			case (q.idx)
				2'd0: d.output_driver_config_reg = hwdata[3:0]; // R20
				2'd1: d.mode = hwdata[3:0]; // R20
				default: ;
			endcase
		end
		// Bus address phase
		d.act = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
		d.wr = hwrite;
		d.idx = decode(haddr[7:0]);
		// Read data sees a write of the previous cycle
		if (d.act && !hwrite) begin
			case (d.idx)
				2'd0: d.rdata = {28'h0, d.output_driver_config_reg};
				2'd1: d.rdata = {28'h0, d.mode};
				2'd2: d.rdata = {14'h0, q.ser, q.two, q.dcs, q.term, q.cur_sel,
					q.link, q.last_per};
				default: d.rdata = 32'h0;
			endcase
		end

		// Encode period measurement
		fchg = (q.per_cnt > q.last_per) ? (q.per_cnt - q.last_per > PERIOD_TOL)
			: (q.last_per - q.per_cnt > PERIOD_TOL);
		if (edge_s) begin
			d.per_cnt = 8'h00;
			d.last_per = q.per_cnt;
		end else if (q.per_cnt != STOP_CYC) begin
			d.per_cnt = q.per_cnt + 8'h01;
		end

		// Lock sequence
		case (q.link)
			ST_IDLE: begin
				if (edge_s) begin
					d.link = ST_RELOCK;
					d.lock_cnt = 8'h00;
				end
			end
			ST_RELOCK: begin
				d.lock_cnt = q.lock_cnt + 8'h01;
				if (edge_s && fchg) begin
					d.lock_cnt = 8'h00; // R16
				end else if (q.lock_cnt == LOCK_LAST) begin
					d.link = ST_RUN; // R16
				end
			end
			ST_RUN: begin
				if (edge_s && fchg) begin
					d.link = ST_RELOCK; // R16
					d.lock_cnt = 8'h00;
				end
			end
			default: d.link = ST_IDLE;
		endcase
		// Encode stopped
		if (q.per_cnt == STOP_CYC) begin
			d.link = ST_IDLE; // R16
		end

		// Serializer, one bit period per cycle
		if (!run) begin
			d.la = 4'h0;
			d.lb = 4'h0;
			d.fbc = 1'b0;
			d.busy = 1'b0;
			d.odd = 1'b1;
		end else begin
			d.fbc = ~q.fbc; // R25 R3
			if (edge_s) begin
				// New result on all channels at once
				for (int c = 0; c < 4; c++) begin
					w = build_word(ch_data[c*12 +: 12], ch_overrange[c], q.ser); // R19
					d.la[c] = w[15]; // R24
					d.lb[c] = q.two & w[14]; // R1 R21
					d.sh[c*16 +: 16] = q.two ? (w << 2) : (w << 1); // R1
				end
				d.pos = 4'h0;
				d.len = len_of(q.ser, q.two);
				d.busy = 1'b1;
				d.odd = ~q.odd;
				d.cur_two = q.two;
				d.cur_ser = q.ser;
			end else if (q.busy && ({1'b0, q.pos} != q.len - 5'd1)) begin
				// Next bit(s) of each word
				for (int c = 0; c < 4; c++) begin
					d.la[c] = q.sh[c*16 + 15]; // R24
					d.lb[c] = q.cur_two & q.sh[c*16 + 14]; // R21
					d.sh[c*16 +: 16] = q.cur_two ? (q.sh[c*16 +: 16] << 2)
						: (q.sh[c*16 +: 16] << 1);
				end
				d.pos = q.pos + 4'h1;
			end else begin
				// Word done, lanes rest low
				d.busy = 1'b0;
				d.la = 4'h0;
				d.lb = 4'h0;
			end
		end
		// Frame marker
		if (d.cur_two && d.cur_ser == SER_14) begin
			d.fr = d.busy & ~d.odd; // R5
		end else begin
			d.fr = d.busy & ({1'b0, d.pos} < (d.len >> 1)); // R4 R9
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= ST_RST;
		end else begin
			q <= d; // R25
		end
	end

	// Outputs
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = q.rdata;
	assign sdo_out = 1'b0;
	assign sdo_oe = 1'b0;
	assign lane_a = q.la;
	assign lane_b = q.lb;
	assign lane_b_enable = q.two; // R21
	assign forwarded_bit_clock = q.fbc;
	assign frame_marker = q.fr;
	assign outputs_valid = (q.link == ST_RUN);
	assign drive_current_sel = q.cur_sel;
	assign drive_doubled = q.term; // R13
	assign term_enable = q.term;
	assign dcs_enable = q.dcs;

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_relock_time: assert property ($rose(q.link == ST_RUN) |-> // R16
		$past(q.lock_cnt) == LOCK_LAST)
		else $error("run entered before relock time");
	a_quiet_unlocked: assert property (!$past(run) |-> lane_a == 4'h0 // R16
		&& lane_b == 4'h0 && !forwarded_bit_clock && !frame_marker)
		else $error("lanes active while unlocked");
	a_clock_toggle: assert property (run && $past(run) |=> // R25
		forwarded_bit_clock != $past(forwarded_bit_clock))
		else $error("forwarded clock stalled");
	a_lane_b_idle: assert property (run && !q.two && !q.cur_two |=> lane_b == 4'h0) // R21
		else $error("second lane active in one-lane mode");
	a_frame_first: assert property ($rose(frame_marker) |-> q.pos == 4'h0) // R4
		else $error("frame marker not at first bit");
	a_frame_half: assert property (q.cur_two && q.cur_ser == SER_14 && q.busy // R5
		&& $past(q.busy) && q.pos != 4'h0 |-> $stable(frame_marker))
		else $error("frame marker moved inside word");
	a_strap_current: assert property (q.sy2[0] && q.sy2[2] |=> // R12
		drive_current_sel == CUR_1P75)
		else $error("strap current not applied");
	a_strap_dcs: assert property (q.sy2[0] |=> dcs_enable) // R17
		else $error("stabilizer off in strap mode");
	a_mode_write: assert property (q.act && q.wr && q.idx == 2'd1 |=> // R20
		q.mode == $past(hwdata[3:0]))
		else $error("mode write lost");
	c_lock: cover property ($rose(q.link == ST_RUN));
	c_relock: cover property (q.link == ST_RUN ##1 q.link == ST_RELOCK);
	c_half_frame: cover property (q.cur_two && q.cur_ser == SER_14 && $fell(frame_marker));
	c_one_lane: cover property (!q.cur_two && $rose(frame_marker));
endmodule : qaos_serializer
`default_nettype wire

// ### qaos_rx_model.sv
// Purpose: Receiver model for the serialized lanes of channel 0
// Assumes: One bit period per half cycle of the forwarded clock
// Notes: Gathers word_bits bits from each frame start
`timescale 1ns/1ps
`default_nettype none
module qaos_rx_model (
	input wire logic forwarded_bit_clock,
	input wire logic frame_marker,
	input wire logic [3:0] lane_a,
	input wire logic [3:0] lane_b,
	input wire logic lane_b_enable,
	input wire logic [4:0] word_bits,
	output var logic [15:0] word_q,
	output var logic [15:0] word_count
);
	logic [15:0] shift_q = 16'h0000; // Bits gathered so far
	logic [4:0] got_q = 5'h1F; // Count of bits gathered, none before a frame
	logic frame_q = 1'b0; // Frame level at last sample
	logic [15:0] word_r = 16'h0000; // Last complete word
	logic [15:0] count_r = 16'h0000; // Frame starts seen
	// One driver for each reported value
	assign word_q = word_r;
	assign word_count = count_r;
	// Sample mid-bit after both clock edges
	always @(forwarded_bit_clock) begin
		#50;
		// Word boundary where the frame rises
		if (frame_marker && !frame_q) begin
			shift_q = 16'h0000;
			got_q = 5'h00;
			count_r = count_r + 16'h0001;
		end
		frame_q = frame_marker;
		if (got_q < word_bits) begin
			// Two lanes give a bit pair, lane A first
			if (lane_b_enable) begin
				shift_q = {shift_q[13:0], lane_a[0], lane_b[0]};
				got_q = got_q + 5'h02;
			end else begin
				shift_q = {shift_q[14:0], lane_a[0]};
				got_q = got_q + 5'h01;
			end
			if (got_q >= word_bits) word_r = shift_q;
		end
	end
endmodule : qaos_rx_model
`default_nettype wire

// ### quad_adc_lvds_output_serializer_tb.sv
// Purpose: Self-checking bench for the quad serializer
// Assumes: Zero wait register slave, encode period of 800 ns
// Notes: Table rows cover registers and link modes
`timescale 1ns/1ps
`default_nettype none
module quad_adc_lvds_output_serializer_tb
	import qaos_pkg::*;
;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] rd;
		logic [2:0] cur;
		logic term;
		logic dcs;
		logic [4:0] bits;
		logic [15:0] word;
		int frames;
	} qaos_row_type; // One table case
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0; // Bus side
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd; // Bus data
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic enc = 1'b0, enc_run = 1'b1, strap = 1'b0, cs = 1'b0, sck = 1'b0, sdo = 1'b0; // Pins
	logic [4:0] rx_bits = 5'h00; // Word length for the receiver
	logic [3:0] ovr = 4'hF; // Positive overrange on every channel
	logic hreadyout, hresp, sdo_out, sdo_oe, lbe, fclk, frame, valid, dbl, term, dcs;
	logic [31:0] hrdata;
	logic [3:0] lane_a, lane_b;
	logic [2:0] cur;
	logic [15:0] word_q, word_count, frames;
	int mismatches = 0, check_count = 0, cycles = 0, n;
	qaos_row_type rows [10] = '{
		'{ADDR_DRV, 32'h00000000, 4'h0, CUR_1P75, 1'b0, 1'b1, 5'h00, 16'h0000, 0},
		'{ADDR_DRV, 32'h00000009, 4'h9, CUR_2P1, 1'b1, 1'b1, 5'h00, 16'h0000, 0},
		'{ADDR_DRV, 32'h00000007, 4'h7, CUR_4P5, 1'b0, 1'b1, 5'h00, 16'h0000, 0},
		'{8'h0C, 32'hFFFFFFFF, 4'h0, CUR_4P5, 1'b0, 1'b1, 5'h00, 16'h0000, 0},
		'{ADDR_DRV, 32'hFFFFFFF4, 4'h4, CUR_3P5, 1'b0, 1'b1, 5'h00, 16'h0000, 0},
		'{ADDR_MODE, 32'h00000008, 4'h8, CUR_3P5, 1'b0, 1'b0, 5'h00, 16'h0000, 0},
		'{ADDR_MODE, 32'h00000000, 4'h0, CUR_3P5, 1'b0, 1'b1, 5'h10, 16'hA5CC, 8},
		'{ADDR_MODE, 32'h00000002, 4'h2, CUR_3P5, 1'b0, 1'b1, 5'h0E, 16'h2973, 4},
		'{ADDR_MODE, 32'h00000004, 4'h4, CUR_3P5, 1'b0, 1'b1, 5'h0C, 16'h0A5C, 8},
		'{ADDR_MODE, 32'h00000005, 4'h5, CUR_3P5, 1'b0, 1'b1, 5'h08, 16'h00A5, 8}
	};
	qaos_serializer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_clock_pos(enc),
		.sample_clock_neg(1'b0), .programming_mode_strap(strap), .cs_pin(cs), .sck_pin(sck),
		.sdo_in(sdo), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ch_data({4{12'hA5C}}),
		.ch_overrange(ovr), .lane_a(lane_a), .lane_b(lane_b), .lane_b_enable(lbe),
		.forwarded_bit_clock(fclk), .frame_marker(frame), .outputs_valid(valid),
		.drive_current_sel(cur), .drive_doubled(dbl), .term_enable(term), .dcs_enable(dcs));
	qaos_rx_model rx_u (.forwarded_bit_clock(fclk), .frame_marker(frame), .lane_a(lane_a),
		.lane_b(lane_b), .lane_b_enable(lbe), .word_bits(rx_bits), .word_q(word_q),
		.word_count(word_count));
	// Bus clock
	initial forever #50 hclk = ~hclk;
	// Encode clock, phase unrelated to the bus clock
	initial begin
		#837;
		forever begin
			if (enc_run) enc = ~enc;
			#400;
		end
	end
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// One single word transfer, waits for ready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	// Counts and the verdict
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge hclk);
		check(32'({valid, fclk, frame, term, dcs, lbe, cur}), 32'h01C, "reset outputs");
		hresetn <= 1'b1;
		n = 0;
		while (valid !== 1'b1) begin
			@(posedge hclk);
			n++;
		end
		check(32'(n > 249 && n < 271), 32'h1, "relock time");
		bus(1'b0, ADDR_DRV, 32'h0);
		check(rd, 32'h4, "driver reset");
		bus(1'b0, ADDR_MODE, 32'h0);
		check(rd, 32'h0, "mode reset");
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			check(rd, 32'(rows[i].rd), "readback");
			repeat (3) @(posedge hclk);
			check(32'(cur), 32'(rows[i].cur), "current");
			check(32'({term, dbl}), 32'({2{rows[i].term}}), "termination");
			check(32'(dcs), 32'(rows[i].dcs), "stabilizer");
			check(32'(lbe), 32'(!(rows[i].a == ADDR_MODE && rows[i].d[0])), "lanes");
			if (rows[i].bits != 5'h00) begin
				rx_bits <= rows[i].bits;
				repeat (32) @(posedge hclk);
				frames = word_count;
				repeat (64) begin
					@(posedge hclk);
					if (lane_a !== 4'h0 && lane_a !== 4'hF) check(32'(lane_a), 32'h0, "skew");
					if (!lbe && lane_b !== 4'h0) check(32'(lane_b), 32'h0, "idle lane");
				end
				check(32'(word_count - frames), 32'(rows[i].frames), "frames");
				check(32'(word_q), 32'(rows[i].word), "word");
			end
			$display("test row %0d done", i);
		end
		// Pad bits go low without overrange
		ovr <= 4'h0;
		bus(1'b1, ADDR_MODE, 32'h0);
		rx_bits <= 5'h10;
		repeat (40) @(posedge hclk);
		check(32'(word_q), 32'hA5C0, "pad bits low");
		$display("test pad done");
		enc_run = 1'b0;
		n = 0;
		while (valid === 1'b1) begin
			@(posedge hclk);
			n++;
		end
		check(32'(n > 239 && n < 271), 32'h1, "stop time");
		check(32'(fclk), 32'h0, "clock parked");
		$display("test stop done");
		strap <= 1'b1;
		cs <= 1'b1;
		sck <= 1'b1;
		sdo <= 1'b1;
		repeat (6) @(posedge hclk);
		check(32'({cur, term, dbl, dcs, lbe}), 32'h0E, "strap high");
		check(32'({hreadyout, hresp, sdo_oe, sdo_out}), 32'h8, "pin not driven");
		cs <= 1'b0;
		sck <= 1'b0;
		sdo <= 1'b0;
		bus(1'b1, ADDR_MODE, 32'h8);
		repeat (6) @(posedge hclk);
		check(32'({cur, term, dbl, dcs, lbe}), 32'h43, "strap low");
		$display("test strap done");
		print_verdict();
	end
endmodule : quad_adc_lvds_output_serializer_tb
`default_nettype wire
